// >>> birh_pkg.sv
// Purpose: Shared constants and carriers for the board interrupt routing hub
// Assumes: Single 10 MHz clock domain, synchronous active-low reset
// Notes:   Level numbering follows the recommended source map
package birh_pkg;

  // ----------------------------------------
  // Widths and counts
  // ----------------------------------------
  localparam int NUM_LEGACY     = 16;
  localparam int NUM_PCI        = 16;
  localparam int NUM_LEVELS     = 32;
  localparam int LEVEL_W        = 5;
  localparam int MSG_BITS       = 8;

  // ----------------------------------------
  // Fixed level positions
  // ----------------------------------------
  localparam logic [4:0] LVL_PROC_REQ = 5'h00;
  localparam logic [4:0] LVL_CASCADE  = 5'h02;
  localparam logic [4:0] LVL_SERIAL_A = 5'h03;
  localparam logic [4:0] LVL_SERIAL_B = 5'h04;
  localparam logic [4:0] LVL_DISK     = 5'h0E;
  localparam logic [4:0] LVL_PCI_BASE = 5'h10;
  localparam int          CASCADE_IN  = 2;

  // ----------------------------------------
  // Message type codes
  // ----------------------------------------
  localparam logic [1:0] MSG_FIXED  = 2'h0;
  localparam logic [1:0] MSG_NMI    = 2'h1;
  localparam logic [1:0] MSG_SMI    = 2'h2;

  // ----------------------------------------
  // Serial link timing
  // ----------------------------------------
  localparam int HOST_CLK_DIV   = 4;
  localparam int LINK_HALF_CYC  = HOST_CLK_DIV / 2;
  localparam int START_BITS     = 1;
  localparam int FRAME_BITS     = START_BITS + 2 + MSG_BITS;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] PEND_RST = 16'h0000;

  // Message carried to the serial sender
  typedef struct packed {
    logic [1:0] kind;
    logic [4:0] level;
  } birh_msg_t;

endpackage : birh_pkg

// >>> birh_serial_tx.sv
// Purpose: Sends one message as a serial frame on two data lines
// Assumes: Link clock is the system clock divided by four
// Notes:   Data lines are open drain; enable low means drive low
`timescale 1ns/1ps
module birh_serial_tx
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              clkEn,
  // Message request
  input  wire logic              msgValid,
  input  wire birh_pkg::birh_msg_t msgIn,
  output logic                   msgReady,
  // Link pins
  output logic                   linkClk,
  output logic                   dat0Out,
  output logic                   dat0OeN,
  output logic                   dat1Out,
  output logic                   dat1OeN
);

  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} birh_txst_t;

  birh_txst_t  state_reg;
  logic [1:0]  div_reg;
  logic [3:0]  bitCnt_reg;
  logic [10:0] shift_reg;

  // ----------------------------------------
  // Link clock divider
  // ----------------------------------------
  // Divide by four
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      div_reg <= 2'h0;
    else if (clkEn)
      div_reg <= div_reg + 2'h1;
  end

  assign linkClk = div_reg[1];
  logic bitTick;
  assign bitTick  = (div_reg == 2'h3);
  assign msgReady = (state_reg == TX_IDLE) && bitTick;

  // ----------------------------------------
  // Frame shifter
  // ----------------------------------------
  // Drive both data lines
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_reg  <= TX_IDLE;
      bitCnt_reg <= 4'h0;
      shift_reg  <= 11'h7FF;
    end
    else if (clkEn && bitTick)
    begin
      case (state_reg)
        TX_IDLE:
          if (msgValid)
          begin
            shift_reg  <= {1'b0, msgIn.kind, 1'b0, msgIn.level, 2'h3};
            bitCnt_reg <= 4'(birh_pkg::FRAME_BITS);
            state_reg  <= TX_SHIFT;
          end
        TX_SHIFT:
        begin
          shift_reg <= {shift_reg[9:0], 1'b1};
          if (bitCnt_reg == 4'h1)
            state_reg <= TX_IDLE;
          bitCnt_reg <= bitCnt_reg - 4'h1;
        end
        default:
          state_reg <= TX_IDLE;
      endcase
    end
  end

  // Lines float high when idle; a zero is actively pulled low
  assign dat0Out = 1'b0;
  assign dat1Out = 1'b0;
  assign dat0OeN = (state_reg == TX_SHIFT) ? shift_reg[10] : 1'b1;
  assign dat1OeN = (state_reg == TX_SHIFT) ? shift_reg[9]  : 1'b1;

endmodule : birh_serial_tx

// >>> birh_hub.sv
// Purpose: Board interrupt routing hub, legacy and serial delivery modes
// Assumes: All interrupt inputs arrive from pins and are synchronised here
// Notes:   Legacy sources active high except the clock interrupt
`timescale 1ns/1ps
module birh_hub
#(
  parameter int NUM_PCI = birh_pkg::NUM_PCI
)
(
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire logic               clkEn,
  // Mode straps
  input  wire logic               advMode,
  input  wire logic               serialSwap,
  // Interrupt sources
  input  wire logic [15:0]        legacyReq,
  input  wire logic               rtc_int_req_n,
  input  wire logic [NUM_PCI-1:0] pciInt,
  input  wire logic               nmiReq,
  input  wire logic               bridgeSmi,
  input  wire logic               mgmtSmi,
  // Legacy mode output
  output logic                    processor_int_request,
  output logic                    sys_mgmt_int_n,
  // Acknowledge from the servicing processor
  input  wire logic               intAck,
  // Serial interrupt link
  output logic                    linkClk,
  output logic                    dat0Out,
  output logic                    dat0OeN,
  output logic                    dat1Out,
  output logic                    dat1OeN
);

  localparam int NSRC = 16 + NUM_PCI + 2;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [NSRC-1:0] meta_reg;
  logic [NSRC-1:0] sync_reg;
  logic [NSRC-1:0] prev_reg;
  logic [NSRC-1:0] rawIn;
  logic [15:0]     legacyMapped;

  always_comb
  begin
    legacyMapped    = legacyReq;
    legacyMapped[8] = ~rtc_int_req_n;
    if (serialSwap)
    begin
      legacyMapped[3] = legacyReq[4];
      legacyMapped[4] = legacyReq[3];
    end
  end

  assign rawIn = {(bridgeSmi | mgmtSmi), nmiReq, pciInt, legacyMapped};

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else if (clkEn)
    begin
      meta_reg <= rawIn;
      sync_reg <= meta_reg;
    end
  end

  // ----------------------------------------
  // Legacy cascade controllers
  // ----------------------------------------
  logic [7:0]  secPend;
  logic [7:0]  primIn;
  logic [15:0] legPend_reg;
  logic [15:0] ackMask;

  // Level latch; cleared by acknowledge of the lowest pending primary input, or of the lowest secondary level if that input is the cascade
  function automatic logic [15:0] lowestBit(input logic [15:0] v);
    lowestBit = v & (~v + 16'h0001);
  endfunction : lowestBit

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      legPend_reg <= birh_pkg::PEND_RST;
    else if (clkEn)
      legPend_reg <= (legPend_reg & ~ackMask)
                     | (advMode ? 16'h0000 : (sync_reg[15:0] & ~prev_reg[15:0]));
  end

  assign secPend = legPend_reg[15:8];

  always_comb
  begin
    primIn = legPend_reg[7:0];
    primIn[birh_pkg::CASCADE_IN] = |secPend;
  end

  // Ack clears one level
  // Picking the cascade slot must clear a secondary level, or it never drops
  always_comb
  begin
    ackMask = lowestBit({8'h00, primIn});
    if (ackMask[birh_pkg::CASCADE_IN])
      ackMask = lowestBit({secPend, 8'h00});
    if (!intAck)
      ackMask = 16'h0000;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      processor_int_request <= 1'b0;
    else if (clkEn)
      processor_int_request <= !advMode && (|primIn);
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      sys_mgmt_int_n <= 1'b1;
    else if (clkEn)
      sys_mgmt_int_n <= !(!advMode && sync_reg[NSRC-1]);
  end

  // ----------------------------------------
  // Edge detect and pending events
  // ----------------------------------------
  logic [NSRC-1:0] evPend_reg;
  logic [NSRC-1:0] grant;
  logic            msgReady;
  logic            msgValid;
  birh_pkg::birh_msg_t msg;
  int              selIdx;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      prev_reg <= '0;
    else if (clkEn)
      prev_reg <= sync_reg;
  end

  // Priority pick: lowest index wins
  always_comb
  begin
    grant  = '0;
    selIdx = 0;
    for (int i = NSRC - 1; i >= 0; i--)
      if (evPend_reg[i])
      begin
        selIdx = i;
      end
    if (|evPend_reg)
      grant[selIdx] = 1'b1;
  end

  assign msgValid = advMode && (|evPend_reg);

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      evPend_reg <= '0;
    else if (clkEn)
      evPend_reg <= (evPend_reg & ~((msgValid && msgReady) ? grant : '0))
                    | (advMode ? (sync_reg & ~prev_reg) : '0);
  end

  // ----------------------------------------
  // Message build
  // ----------------------------------------
  // Identify the interrupt
  always_comb
  begin
    msg.kind  = birh_pkg::MSG_FIXED;
    msg.level = 5'(selIdx);
    if (selIdx == NSRC - 2)
    begin
      msg.kind  = birh_pkg::MSG_NMI;
      msg.level = 5'h00;
    end
    else if (selIdx == NSRC - 1)
    begin
      msg.kind  = birh_pkg::MSG_SMI;
      msg.level = 5'h00;
    end
    else if (selIdx >= 16)
      msg.level = 5'(selIdx);
  end

  // ----------------------------------------
  // Serial sender
  // ----------------------------------------
  // Three-wire link
  birh_serial_tx u_tx
  (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .msgValid (msgValid),
    .msgIn    (msg),
    .msgReady (msgReady),
    .linkClk  (linkClk),
    .dat0Out  (dat0Out),
    .dat0OeN  (dat0OeN),
    .dat1Out  (dat1Out),
    .dat1OeN  (dat1OeN)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_legacyQuiet;
    @(posedge mclk) disable iff (!rst_n)
    (clkEn && advMode) |=> !processor_int_request;
  endproperty
  a_legacyQuiet: assert property (p_legacyQuiet) else $error("request line set in adv mode");

  property p_cascade;
    @(posedge mclk) disable iff (!rst_n)
    (clkEn && !advMode && (|secPend)) |=> processor_int_request;
  endproperty
  a_cascade: assert property (p_cascade) else $error("cascade not on input 2");

  property p_reqLine;
    @(posedge mclk) disable iff (!rst_n)
    (clkEn && !advMode && (|primIn)) |=> processor_int_request;
  endproperty
  a_reqLine: assert property (p_reqLine) else $error("request line missing");

  property p_edgeCaught;
    @(posedge mclk) disable iff (!rst_n)
    (clkEn && advMode && sync_reg[0] && !prev_reg[0]) |=> evPend_reg[0];
  endproperty
  a_edgeCaught: assert property (p_edgeCaught) else $error("edge not pending");

  property p_sent;
    @(posedge mclk) disable iff (!rst_n)
    (clkEn && msgValid && msgReady) |=> !dat0OeN;
  endproperty
  a_sent: assert property (p_sent) else $error("no frame start");

  property p_idleLines;
    @(posedge mclk) disable iff (!rst_n)
    !advMode [*8] |-> (dat0OeN && dat1OeN);
  endproperty
  a_idleLines: assert property (p_idleLines) else $error("lines driven when idle");

  property p_divide;
    @(posedge mclk) disable iff (!rst_n)
    (clkEn && $rose(linkClk)) ##1 clkEn |-> linkClk ##1 !linkClk;
  endproperty
  a_divide: assert property (p_divide) else $error("link clock period wrong");

  property p_noRepeat;
    @(posedge mclk) disable iff (!rst_n)
    (clkEn && sync_reg[0] && prev_reg[0] && !evPend_reg[0]) |=> !evPend_reg[0];
  endproperty
  a_noRepeat: assert property (p_noRepeat) else $error("repeat message");

  property p_ackOne;
    @(posedge mclk) disable iff (!rst_n)
    (clkEn && intAck && !advMode && (|primIn)
      && ((sync_reg[15:0] & ~prev_reg[15:0]) == 16'h0000))
      |=> ($countones(legPend_reg) == $countones($past(legPend_reg)) - 1);
  endproperty
  a_ackOne: assert property (p_ackOne) else $error("ack did not clear one level");

  property p_nmiKind;
    @(posedge mclk) disable iff (!rst_n)
    (msgValid && grant[NSRC-2]) |-> ((msg.kind == birh_pkg::MSG_NMI) && (msg.level == 5'h00));
  endproperty
  a_nmiKind: assert property (p_nmiKind) else $error("nmi message wrong");

  property p_smiLine;
    @(posedge mclk) disable iff (!rst_n)
    (clkEn && !advMode && sync_reg[NSRC-1]) |=> !sys_mgmt_int_n;
  endproperty
  a_smiLine: assert property (p_smiLine) else $error("management line not low");

endmodule : birh_hub

// >>> birh_link_rx.sv
// Purpose: Processor-side receiver model for the serial interrupt link
// Assumes: Data lines are open drain with pull-ups, idle high
// Notes:   Samples mid-cell in mclk; never drives, so the hub owns the lines
`timescale 1ns/1ps
module birh_link_rx
(
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  // Resolved data lines
  input  wire logic                 dat0,
  input  wire logic                 dat1,
  // Decoded message
  output logic                      rxStb,
  output logic                      rxOk,
  output birh_pkg::birh_msg_t       rxMsg
);
  int          cntReg;
  logic [10:0] shReg;
  logic [10:0] sh1Reg;

  // ----------------------------------------
  // Frame capture
  // ----------------------------------------
  // decode one frame
  always @(posedge mclk)
  begin
    rxStb <= 1'b0;
    if (!rst_n)
      cntReg <= 0;
    else if (cntReg == 0)
      cntReg <= dat0 ? 0 : 1;
    else
    begin
      cntReg <= (cntReg == 42) ? 0 : cntReg + 1;
      if (cntReg % 4 == 1)
      begin
        shReg  <= {shReg[9:0], dat0};
        sh1Reg <= {sh1Reg[9:0], dat1};
      end
      if (cntReg == 42)
      begin
        rxStb       <= 1'b1;
        rxOk        <= ~shReg[10] & ~shReg[7] & shReg[1] & shReg[0]
                       & (sh1Reg == {shReg[9:0], 1'b1});
        rxMsg.kind  <= shReg[9:8];
        rxMsg.level <= shReg[6:2];
      end
    end
  end
endmodule : birh_link_rx

// >>> birh_hub_tb_top.sv
// Purpose: Self-checking bench for the routing hub
// Assumes: 10 MHz clock, pull-ups on the link data lines
// Notes:   A queue model holds expected messages; each frame pops one
`timescale 1ns/1ps
module birh_hub_tb_top;
  logic                      mclk, rst_n, clkEn, advMode, serialSwap, rtc_int_req_n;
  logic                      nmiReq, bridgeSmi, mgmtSmi, intAck;
  logic [15:0]               legacyReq;
  logic [15:0]               pciInt;
  logic                      processor_int_request, sys_mgmt_int_n, linkClk;
  logic                      dat0Out, dat0OeN, dat1Out, dat1OeN, rxStb, rxOk;
  birh_pkg::birh_msg_t       rxMsg;
  int                        failures, cmp_count, seed, i, k, n, e, expQ[$];
  logic                      prev;
  wire                       dat0Wire = dat0OeN ? 1'b1 : dat0Out;
  wire                       dat1Wire = dat1OeN ? 1'b1 : dat1Out;

  birh_hub birh_hub_inst (.mclk, .rst_n, .clkEn, .advMode, .serialSwap, .legacyReq,
    .rtc_int_req_n, .pciInt, .nmiReq, .bridgeSmi, .mgmtSmi, .processor_int_request,
    .sys_mgmt_int_n, .intAck, .linkClk, .dat0Out, .dat0OeN, .dat1Out, .dat1OeN);
  birh_link_rx birh_link_rx_inst (.mclk, .rst_n, .dat0(dat0Wire), .dat1(dat1Wire), .rxStb,
    .rxOk, .rxMsg);

  always #50 mclk = ~mclk;

  // ----------------------------------------
  // Checking and drive tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // Source numbers: 0-15 legacy, 16-31 PCI, 32 NMI, 33-34 SMI
  task automatic drv(input int s, input logic v);
    if (s == 8)
      rtc_int_req_n <= ~v;
    else if (s < 16)
      legacyReq[s] <= v;
    else if (s < 32)
      pciInt[s-16] <= v;
    else if (s == 32)
      nmiReq <= v;
    else if (s == 33)
      bridgeSmi <= v;
    else
      mgmtSmi <= v;
  endtask : drv

  // Bit 8 marks an unnumbered level, kind sits in bits 6:5
  function automatic int expOf(input int s);
    if (s == 3 || s == 4)
      return serialSwap ? 7 - s : s;
    if (s < 16)
      return s;
    if (s < 32)
      return int'(birh_pkg::LVL_PCI_BASE) + s - 16;
    if (s == 32)
      return 256 | (int'(birh_pkg::MSG_NMI) << 5);
    return 256 | (int'(birh_pkg::MSG_SMI) << 5);
  endfunction : expOf

  // Held source must not resend, so idle 60 cycles after the queue empties
  task automatic drain;
    int j;
    j = 0;
    while (expQ.size() != 0 && j < 200)
    begin
      @(posedge mclk);
      j++;
    end
    if (expQ.size() != 0)
    begin
      failures++;
      end_of_test();
    end
    repeat (60) @(posedge mclk);
  endtask : drain

  task automatic fire(input int s);
    expQ.push_back(expOf(s));
    @(posedge mclk);
    drv(s, 1'b1);
    drain();
    @(posedge mclk);
    drv(s, 1'b0);
    repeat (8) @(posedge mclk);
  endtask : fire

  // ----------------------------------------
  // Frame monitor against the queue model
  // ----------------------------------------
  always @(posedge mclk)
    if (rxStb === 1'b1)
    begin
      chk(rxOk, 1'b1);
      if (expQ.size() == 0)
        chk(1'b1, 1'b0);
      else
      begin
        e = expQ.pop_front();
        chk(rxMsg.kind, e[6:5]);
        if (!e[8])
          chk(rxMsg.level, e[4:0]);
      end
    end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    mclk = 0; rst_n = 0; clkEn = 1; advMode = 0; serialSwap = 0;
    rtc_int_req_n = 1; legacyReq = '0; pciInt = '0; nmiReq = 0;
    bridgeSmi = 0; mgmtSmi = 0; intAck = 0;
    failures = 0; cmp_count = 0; seed = 24731;
    repeat (3) @(posedge mclk);
    #1;
    chk(processor_int_request, 1'b0);
    chk(sys_mgmt_int_n, 1'b1);
    chk(dat0OeN, 1'b1);
    @(posedge mclk);
    rst_n <= 1'b1;
    prev = linkClk;
    n = 0;
    repeat (40)
    begin
      @(posedge mclk);
      #1;
      if (linkClk === 1'b1 && prev === 1'b0)
        n++;
      prev = linkClk;
    end
    chk(n, 10);
    @(posedge mclk);
    clkEn <= 1'b0;
    @(posedge mclk);
    #1 prev = linkClk;
    repeat (8) @(posedge mclk);
    #1 chk(linkClk, prev);
    @(posedge mclk);
    clkEn <= 1'b1;
    $display("link clock test done");
    @(posedge mclk);
    advMode <= 1'b1;
    repeat (4) @(posedge mclk);
    for (i = 0; i < 16; i++)
      fire(i);
    repeat (4) fire(16 + ($unsigned($random(seed)) % 16));
    fire(32);
    fire(33);
    fire(34);
    $display("serial message test done");
    @(posedge mclk);
    serialSwap <= 1'b1;
    @(posedge mclk);
    fire(3);
    fire(4);
    serialSwap <= 1'b0;
    expQ.push_back(5);
    expQ.push_back(expOf(17));
    @(posedge mclk);
    drv(5, 1'b1);
    drv(17, 1'b1);
    drain();
    @(posedge mclk);
    drv(5, 1'b0);
    drv(17, 1'b0);
    $display("swap and ordering test done");
    advMode <= 1'b0;
    repeat (8) @(posedge mclk);
    drv(10, 1'b1);
    k = 0;
    while (processor_int_request !== 1'b1 && k < 20)
    begin
      @(posedge mclk);
      #1;
      k++;
    end
    chk(processor_int_request, 1'b1);
    if (k == 20)
      end_of_test();
    @(posedge mclk);
    intAck <= 1'b1;
    @(posedge mclk);
    intAck <= 1'b0;
    repeat (6) @(posedge mclk);
    chk(processor_int_request, 1'b0);
    drv(10, 1'b0);
    bridgeSmi <= 1'b1;
    repeat (6) @(posedge mclk);
    chk(sys_mgmt_int_n, 1'b0);
    bridgeSmi <= 1'b0;
    mgmtSmi <= 1'b1;
    repeat (6) @(posedge mclk);
    chk(sys_mgmt_int_n, 1'b0);
    mgmtSmi <= 1'b0;
    repeat (60) @(posedge mclk);
    chk(sys_mgmt_int_n, 1'b1);
    chk(expQ.size(), 0);
    $display("legacy mode test done");
    end_of_test();
  end
endmodule : birh_hub_tb_top
